/* File: core/sre_top.sv */
/*
 * Serial receive error block: APB registers, receive pin synchroniser,
 * framing and parity error flags with read-then-write-0 clearing, reception
 * hold and clock-synchronous transmit block, interrupt status and mask.
 * Assumes one 50 MHz clock and an APB master on the same clock.
 */
// Added by the designer: the register addresses and the APB register port.
// Behaviour
// [R1] Set framing error when the first stop bit of a character is 0.
// [R2] With two stop bits, check only the first one.
// [R3] Framing error clears by reset, standby, or write 0 after reading 1.
// [R4] Turning receive enable off leaves the framing error flag unchanged.
// [R5] On framing error load the data register, do not set data full.
// [R6] No further reception while the framing error flag is set.
// [R7] Set parity error when ones count disagrees with selected parity.
// [R8] Parity error clears by reset, standby, or write 0 after reading 1.
// [R9] Turning receive enable off leaves the parity error flag unchanged.
// [R10] On parity error load the data register, do not set data full.
// [R11] No further reception while the parity error flag is set.
// [R12] In synchronous mode, block transmission while an error flag stands.
// [R13] Writing 1 does nothing; write 0 clears only flags seen as 1.
`timescale 1ns/1ps
module sre_top
   import sre_pkg::*;
#(
   parameter int BAUD_W = 16
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_pin,
   input  wire logic        standby,
   output logic             tx_allow,
   output logic             irq
);
   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   logic              rx_s1_q, rx_s2_q, rx_s3_q, rx_filt_q;
   logic              re_q, sync_q;
   logic [3:0]        mode_q;
   logic [BAUD_W-1:0] baud_q;
   logic              fer_q, per_q, receive_data_full_flag_q;
   logic [2:0]        seen_q;      // flags read back as 1: receive_data_full_flag, fer, per
   logic [7:0]        rdata_q;
   logic [2:0]        irq_st_q, irq_msk_q;
   logic [31:0]       prdata_q;
   logic              rx_done, rx_perr, rx_ferr, rx_run;
   logic [7:0]        rx_data;
   logic              acc, wr, rd, mapped;
   logic              wr_st, wr_ct, wr_md, wr_bd, wr_iq, wr_im;
   logic              clr_fer, clr_per, clr_receive_data_full_flag;
   logic              set_fer, set_per, set_receive_data_full_flag;
   logic [7:0]        status_w;

   // -------------------------------------------------------------------
   // apb decode
   // -------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign acc    = psel && penable;
   assign wr     = acc && pwrite;
   assign rd     = acc && !pwrite;
   assign mapped = hit(paddr, SRE_OFS_STATUS) || hit(paddr, SRE_OFS_CTRL)
                || hit(paddr, SRE_OFS_MODE) || hit(paddr, SRE_OFS_RDATA)
                || hit(paddr, SRE_OFS_IRQST) || hit(paddr, SRE_OFS_BAUD)
                || hit(paddr, SRE_OFS_IRQMSK);
   assign wr_st  = wr && hit(paddr, SRE_OFS_STATUS);
   assign wr_ct  = wr && hit(paddr, SRE_OFS_CTRL);
   assign wr_md  = wr && hit(paddr, SRE_OFS_MODE);
   assign wr_bd  = wr && hit(paddr, SRE_OFS_BAUD);
   assign wr_iq  = wr && hit(paddr, SRE_OFS_IRQST);
   assign wr_im  = wr && hit(paddr, SRE_OFS_IRQMSK);
   assign pready  = 1'b1;              // zero wait states
   assign pslverr = acc && !mapped;    // unmapped address answers an error
   assign prdata  = prdata_q;

   assign status_w = {1'b0, receive_data_full_flag_q, 1'b0, fer_q, per_q, 3'b000};

   // read data captured in the setup cycle, so it comes from a flip-flop
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SRE_OFS_STATUS: prdata_q <= {24'h00_0000, status_w};
            SRE_OFS_CTRL:   prdata_q <= {30'h0000_0000, sync_q, re_q};
            SRE_OFS_MODE:   prdata_q <= {28'h000_0000, mode_q};
            SRE_OFS_RDATA:  prdata_q <= {24'h00_0000, rdata_q};
            SRE_OFS_IRQST:  prdata_q <= {29'h0000_0000, irq_st_q};
            SRE_OFS_BAUD:   prdata_q <= {{(32-BAUD_W){1'b0}}, baud_q};
            SRE_OFS_IRQMSK: prdata_q <= {29'h0000_0000, irq_msk_q};
            default:        prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         re_q   <= 1'b0;
         sync_q <= 1'b0;
         mode_q <= SRE_MODE_RST;
         baud_q <= BAUD_W'(SRE_BAUD_RST);
      end else begin
         if (wr_ct) begin
            re_q   <= pwdata[SRE_CT_RE];
            sync_q <= pwdata[SRE_CT_SYNC];
         end
         if (wr_md) begin
            mode_q <= pwdata[3:0];
         end
         if (wr_bd) begin
            baud_q <= pwdata[BAUD_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // receive pin synchroniser and agreement filter
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_q   <= 1'b1;
         rx_s2_q   <= 1'b1;
         rx_s3_q   <= 1'b1;
         rx_filt_q <= 1'b1;
      end else begin
         rx_s1_q <= rx_pin;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
         if (rx_s2_q == rx_s3_q) begin
            rx_filt_q <= rx_s3_q; // a change counts once two stages agree
         end
      end
   end

   // reception halts while an error flag stands, when disabled or in standby
   assign rx_run = re_q && !standby && !fer_q && !per_q; // [R6] [R11]

   sre_rx_frame u_rx (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .rx_level   (rx_filt_q),
      .run        (rx_run),
      .bit_cycles (16'(baud_q)),
      .par_en     (mode_q[SRE_MD_PEN]),
      .par_odd    (mode_q[SRE_MD_ODD]),
      .two_stop   (mode_q[SRE_MD_STP2]),
      .seven_bits (mode_q[SRE_MD_CH7]),
      .done       (rx_done),
      .data_q     (rx_data),
      .perr_q     (rx_perr),
      .ferr_q     (rx_ferr)
   );

   // -------------------------------------------------------------------
   // error and data-full flags
   // -------------------------------------------------------------------
   assign set_fer  = rx_done && rx_ferr;                             // [R1]
   assign set_per  = rx_done && rx_perr;                             // [R7]
   assign set_receive_data_full_flag = rx_done && !rx_ferr && !rx_perr;                // [R5] [R10]
   // a 0 written clears only a flag earlier read back as 1
   assign clr_fer  = wr_st && !pwdata[SRE_ST_FER] && seen_q[1];      // [R3] [R13]
   assign clr_per  = wr_st && !pwdata[SRE_ST_PER] && seen_q[0];      // [R8] [R13]
   assign clr_receive_data_full_flag = wr_st && !pwdata[SRE_ST_RECEIVE_DATA_FULL_FLAG] && seen_q[2];

   // set beats software clear; receive enable plays no part here [R4] [R9]
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fer_q  <= 1'b0;
         per_q  <= 1'b0;
         receive_data_full_flag_q <= 1'b0;
      end else if (standby) begin
         fer_q  <= 1'b0; // [R3]
         per_q  <= 1'b0; // [R8]
         receive_data_full_flag_q <= 1'b0;
      end else begin
         if (set_fer) begin
            fer_q <= 1'b1;
         end else if (clr_fer) begin
            fer_q <= 1'b0; // [R3]
         end
         if (set_per) begin
            per_q <= 1'b1;
         end else if (clr_per) begin
            per_q <= 1'b0; // [R8]
         end
         if (set_receive_data_full_flag) begin
            receive_data_full_flag_q <= 1'b1;
         end else if (clr_receive_data_full_flag) begin
            receive_data_full_flag_q <= 1'b0;
         end
      end
   end

   // remembers which flags software saw as 1; any status write consumes it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= 3'b000;
      end else if (standby || wr_st) begin
         seen_q <= 3'b000; // [R13]
      end else if (rd && hit(paddr, SRE_OFS_STATUS)) begin
         seen_q <= {prdata_q[SRE_ST_RECEIVE_DATA_FULL_FLAG], prdata_q[SRE_ST_FER], prdata_q[SRE_ST_PER]};
      end
   end

   // every finished character lands in the data register, errors or not
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (rx_done) begin
         rdata_q <= rx_data; // [R5] [R10]
      end
   end

   // synchronous-mode transmitter may only run with no error standing
   assign tx_allow = !(sync_q && (fer_q || per_q)); // [R12]

   // -------------------------------------------------------------------
   // interrupt status (write 1 to clear) and mask
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_st_q  <= SRE_IRQ_RST;
         irq_msk_q <= SRE_IRQ_RST;
      end else begin
         irq_st_q <= (irq_st_q & ~(wr_iq ? pwdata[2:0] : 3'b000))
                   | {set_receive_data_full_flag, set_per, set_fer};
         if (wr_im) begin
            irq_msk_q <= pwdata[2:0];
         end
      end
   end

   assign irq = |(irq_st_q & irq_msk_q);

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_read_fer;
      rd && hit(paddr, SRE_OFS_STATUS) && prdata_q[SRE_ST_FER];
   endsequence
   sequence s_write_zero_fer;
      wr_st && !pwdata[SRE_ST_FER] && !set_fer && !standby;
   endsequence

   chk_fer_on_stop: assert property (rx_done && rx_ferr && !standby |=> fer_q) // [R1]
      else $error("framing error not flagged");
   chk_per_on_par: assert property (rx_done && rx_perr && !standby |=> per_q) // [R7]
      else $error("parity error not flagged");
   chk_err_no_full: assert property (rx_done && (rx_ferr || rx_perr) && !receive_data_full_flag_q
                                     |=> !receive_data_full_flag_q) // [R5] [R10]
      else $error("data full set on errored character");
   chk_err_data_load: assert property (rx_done |=> rdata_q == $past(rx_data)) // [R5]
      else $error("received character not loaded");
   chk_hold_on_error: assert property ((fer_q || per_q) |-> !rx_run ##1
                                       !rx_done) // [R6] [R11]
      else $error("reception continued with error flag set");
   chk_re_keeps_flags: assert property (!re_q && !standby && !wr_st
                                        |=> $stable(fer_q) && $stable(per_q)) // [R4] [R9]
      else $error("flags changed while receiver disabled");
   chk_sync_tx_block: assert property (sync_q && per_q |-> !tx_allow) // [R12]
      else $error("transmit allowed with error in synchronous mode");
   chk_fer_read_clear: assert property (s_read_fer ##1 (!wr_st)[*2] ##1
                                        s_write_zero_fer |=> !fer_q) // [R3]
      else $error("framing error not cleared by read then write 0");
   chk_write_one_keeps: assert property (fer_q && wr_st && pwdata[SRE_ST_FER]
                                         && !standby |=> fer_q) // [R13]
      else $error("writing 1 cleared framing error");
   chk_unseen_keeps: assert property (per_q && !seen_q[0] && wr_st && !standby
                                      |=> per_q) // [R13]
      else $error("parity error cleared without prior read");
   chk_irq_level: assert property (irq_st_q[SRE_IQ_FER] && irq_msk_q[SRE_IQ_FER]
                                   |-> irq)
      else $error("interrupt not raised for unmasked event");
endmodule : sre_top

/* File: core/sre_pkg.sv */
/*
 * Shared constants for the serial receive error block: register map, field
 * positions, reset values and receiver states. Assumes a 32-bit APB host.
 */
package sre_pkg;
   // -------------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] SRE_OFS_STATUS = 8'h00;
   localparam logic [7:0] SRE_OFS_CTRL   = 8'h04;
   localparam logic [7:0] SRE_OFS_MODE   = 8'h08;
   localparam logic [7:0] SRE_OFS_RDATA  = 8'h0C;
   localparam logic [7:0] SRE_OFS_IRQST  = 8'h10;
   localparam logic [7:0] SRE_OFS_BAUD   = 8'h14;
   localparam logic [7:0] SRE_OFS_IRQMSK = 8'h18;
   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int SRE_ST_RECEIVE_DATA_FULL_FLAG = 6;  // receive data full
   localparam int SRE_ST_FER  = 4;  // framing error
   localparam int SRE_ST_PER  = 3;  // parity error
   localparam int SRE_CT_RE   = 0;  // receive enable
   localparam int SRE_CT_SYNC = 1;  // clock-synchronous mode
   localparam int SRE_MD_PEN  = 0;  // parity enable
   localparam int SRE_MD_ODD  = 1;  // odd parity
   localparam int SRE_MD_STP2 = 2;  // two stop bits
   localparam int SRE_MD_CH7  = 3;  // seven data bits
   localparam int SRE_IQ_FER  = 0;
   localparam int SRE_IQ_PER  = 1;
   localparam int SRE_IQ_RXF  = 2;
   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [15:0] SRE_BAUD_RST = 16'h01B1; // bit period minus one
   localparam logic [3:0]  SRE_MODE_RST = 4'h0;
   localparam logic [2:0]  SRE_IRQ_RST  = 3'h0;

   typedef enum logic [2:0] {
      SRE_IDLE  = 3'b000,
      SRE_START = 3'b001,
      SRE_DATA  = 3'b010,
      SRE_PAR   = 3'b011,
      SRE_STOP  = 3'b100,
      SRE_STOP2 = 3'b101
   } sre_rx_state_t;

   // true when data plus parity bit disagree with the selected parity
   function automatic logic sre_parity_bad(input logic [7:0] data,
                                           input logic pbit,
                                           input logic odd);
      sre_parity_bad = (^data) ^ pbit ^ odd;
   endfunction : sre_parity_bad
endpackage : sre_pkg

/* File: core/sre_rx_frame.sv */
/*
 * Asynchronous character receiver: start detect, data, optional parity,
 * stop check. Assumes a filtered, synchronised receive level and a run
 * level that drops whenever reception must halt.
 */
`timescale 1ns/1ps
module sre_rx_frame
   import sre_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        rx_level,
   input  wire logic        run,
   input  wire logic [15:0] bit_cycles,
   input  wire logic        par_en,
   input  wire logic        par_odd,
   input  wire logic        two_stop,
   input  wire logic        seven_bits,
   output logic             done,
   output logic [7:0]       data_q,
   output logic             perr_q,
   output logic             ferr_q
);
   sre_rx_state_t state_q;
   logic [15:0]   cnt_q;
   logic [7:0]    shreg_q;
   logic [2:0]    nbit_q;
   logic          pbit_q;
   logic          done_q;
   logic [7:0]    char_w;

   // seven-bit characters arrive one shift short
   assign char_w = seven_bits ? {1'b0, shreg_q[7:1]} : shreg_q;
   assign done   = done_q;

   // -------------------------------------------------------------------
   // frame sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SRE_IDLE;
         cnt_q   <= 16'h0000;
         shreg_q <= 8'h00;
         nbit_q  <= 3'h0;
         pbit_q  <= 1'b0;
         done_q  <= 1'b0;
         data_q  <= 8'h00;
         perr_q  <= 1'b0;
         ferr_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (!run) begin
            state_q <= SRE_IDLE; // abandon any partial character
         end else if (state_q != SRE_IDLE && cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
         end else begin
            case (state_q)
               SRE_IDLE: begin
                  if (!rx_level) begin
                     state_q <= SRE_START;
                     cnt_q   <= {1'b0, bit_cycles[15:1]}; // to mid bit
                  end
               end
               SRE_START: begin
                  state_q <= rx_level ? SRE_IDLE : SRE_DATA;
                  cnt_q   <= bit_cycles;
                  nbit_q  <= seven_bits ? 3'h6 : 3'h7;
               end
               SRE_DATA: begin
                  shreg_q <= {rx_level, shreg_q[7:1]}; // lsb first
                  cnt_q   <= bit_cycles;
                  nbit_q  <= nbit_q - 3'h1;
                  if (nbit_q == 3'h0) begin
                     state_q <= par_en ? SRE_PAR : SRE_STOP;
                  end
               end
               SRE_PAR: begin
                  pbit_q  <= rx_level;
                  cnt_q   <= bit_cycles;
                  state_q <= SRE_STOP;
               end
               SRE_STOP: begin
                  // only the first stop bit is judged [R2]
                  done_q  <= 1'b1;
                  data_q  <= char_w;
                  ferr_q  <= !rx_level; // [R1]
                  perr_q  <= par_en && sre_parity_bad(char_w, pbit_q, par_odd); // [R7]
                  cnt_q   <= bit_cycles;
                  state_q <= two_stop ? SRE_STOP2 : SRE_IDLE;
               end
               SRE_STOP2: begin
                  state_q <= SRE_IDLE; // second stop bit passes unchecked [R2]
               end
               default: begin
                  state_q <= SRE_IDLE;
               end
            endcase
         end
      end
   end
endmodule : sre_rx_frame

/* File: bench/sre_remote_tx.sv */
/*
 * Remote serial transmitter model: drives the receive line with one
 * character for each call of send.
 * Assumes the bench calls send right after a rising edge of clk_sys.
 */
`timescale 1ns/1ps
module sre_remote_tx #(
   parameter int BIT_CYCLES = 16
)
(
   input  wire logic clk_sys,
   output logic      rx_line
);
   // the line idles high between characters
   initial rx_line = 1'h1;

   // one bit time on the line, changed just after an edge
   task automatic put_bit(input logic b);
      rx_line <= b;
      repeat (BIT_CYCLES) @(posedge clk_sys);
   endtask : put_bit

   // start, data lsb first, optional parity, stop bits, then one idle bit
   task automatic send(input logic [7:0] data, input logic par_en, input logic odd,
                       input logic flip, input logic stop1, input logic two,
                       input logic stop2);
      @(posedge clk_sys);
      put_bit(1'h0);
      for (int i = 0; i < 8; i++) begin
         put_bit(data[i]);
      end
      if (par_en) begin
         put_bit(^data ^ odd ^ flip);
      end
      put_bit(stop1);
      if (two) begin
         put_bit(stop2);
      end
      put_bit(1'h1);
   endtask : send
endmodule : sre_remote_tx

/* File: bench/testbench.sv */
/*
 * Self-checking bench for the serial receive error block: APB tasks,
 * one task for each scenario, closing report.
 * Assumes sre_top and the remote transmitter model on one 50 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
   import sre_pkg::*;
();
   // -------------------------------------------------------------------
   // signals and instances
   // -------------------------------------------------------------------
   localparam int          BIT   = 16;
   localparam logic [31:0] ST_RX = 32'h1 << SRE_ST_RECEIVE_DATA_FULL_FLAG;
   localparam logic [31:0] ST_FE = 32'h1 << SRE_ST_FER;
   localparam logic [31:0] ST_PE = 32'h1 << SRE_ST_PER;
   logic        clk_sys;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_pin;
   logic        standby;
   logic        tx_allow;
   logic        irq;
   int          mismatches = 0;
   int          tests_run = 0;

   sre_top #(.BAUD_W(16)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
      .standby(standby), .tx_allow(tx_allow), .irq(irq));
   sre_remote_tx #(.BIT_CYCLES(BIT)) tx_u (.clk_sys(clk_sys), .rx_line(rx_pin));

   // 50 MHz system clock
   initial begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end

   // -------------------------------------------------------------------
   // bus tasks and report
   // -------------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // setup cycle, then access phase held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] r, output logic err);
      int n;
      @(posedge clk_sys);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'h1 && n < 100);
      if (n >= 100) begin
         mismatches++;
         print_verdict();
      end
      r = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(a, 1'h1, d, r, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(a, 1'h0, 32'h0, r, e);
      `CHK(r, exp)
   endtask : rd_chk

   // read status so set flags count as seen, then write 0 into the mask bits
   task automatic clr(input logic [31:0] m);
      logic [31:0] r;
      logic        e;
      apb(SRE_OFS_STATUS, 1'h0, 32'h0, r, e);
      apb(SRE_OFS_STATUS, 1'h1, ~m, r, e);
   endtask : clr

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      rd_chk(SRE_OFS_STATUS, 32'h0);
      rd_chk(SRE_OFS_CTRL, 32'h0);
      rd_chk(SRE_OFS_MODE, 32'h0);
      rd_chk(SRE_OFS_BAUD, {16'h0, SRE_BAUD_RST});
      rd_chk(SRE_OFS_RDATA, 32'h0);
      rd_chk(SRE_OFS_IRQST, 32'h0);
      apb(8'h1C, 1'h1, 32'hFFFF_FFFF, r, e);
      `CHK(e, 1'h1)
      apb(8'h1C, 1'h0, 32'h0, r, e);
      `CHK(r, 32'h0)
      `CHK(tx_allow, 1'h1)
      `CHK(irq, 1'h0)
      wr(SRE_OFS_BAUD, 32'(BIT - 1));
      rd_chk(SRE_OFS_BAUD, 32'(BIT - 1));
      wr(SRE_OFS_CTRL, 32'h1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_good();
      tx_u.send(8'hA5, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
      rd_chk(SRE_OFS_STATUS, ST_RX);
      rd_chk(SRE_OFS_RDATA, 32'hA5);
      clr(ST_RX);
      // seven-bit characters: bit 7 on the line stands in the stop position
      wr(SRE_OFS_MODE, 32'h1 << SRE_MD_CH7);
      tx_u.send(8'hB5, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
      rd_chk(SRE_OFS_STATUS, ST_RX);
      rd_chk(SRE_OFS_RDATA, 32'h35);
      clr(ST_RX);
      wr(SRE_OFS_MODE, 32'h1 << SRE_MD_STP2);
      tx_u.send(8'h3C, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
      rd_chk(SRE_OFS_STATUS, ST_RX);
      rd_chk(SRE_OFS_RDATA, 32'h3C);
      clr(ST_RX);
      $display("test good done");
   endtask : t_good

   task automatic t_frame();
      logic [31:0] r;
      logic        e;
      wr(SRE_OFS_IRQST, 32'h7);
      wr(SRE_OFS_IRQMSK, 32'h1 << SRE_IQ_FER);
      tx_u.send(8'h5A, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
      rd_chk(SRE_OFS_STATUS, ST_FE);
      rd_chk(SRE_OFS_RDATA, 32'h5A);
      rd_chk(SRE_OFS_IRQST, 32'h1 << SRE_IQ_FER);
      wr(SRE_OFS_CTRL, 32'h0);
      rd_chk(SRE_OFS_STATUS, ST_FE);
      wr(SRE_OFS_CTRL, 32'h1);
      tx_u.send(8'h81, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
      rd_chk(SRE_OFS_RDATA, 32'h5A);
      rd_chk(SRE_OFS_STATUS, ST_FE);
      @(negedge clk_sys);
      `CHK(irq, 1'h1)
      wr(SRE_OFS_IRQMSK, 32'h0);
      @(negedge clk_sys);
      `CHK(irq, 1'h0)
      wr(SRE_OFS_IRQMSK, 32'h1 << SRE_IQ_FER);
      wr(SRE_OFS_IRQST, 32'h1 << SRE_IQ_FER);
      @(negedge clk_sys);
      `CHK(irq, 1'h0)
      apb(SRE_OFS_STATUS, 1'h0, 32'h0, r, e);
      wr(SRE_OFS_STATUS, 32'hFFFF_FFFF);
      wr(SRE_OFS_STATUS, 32'h0);
      rd_chk(SRE_OFS_STATUS, ST_FE);
      clr(ST_FE);
      rd_chk(SRE_OFS_STATUS, 32'h0);
      tx_u.send(8'h81, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
      rd_chk(SRE_OFS_RDATA, 32'h81);
      clr(ST_RX);
      $display("test frame done");
   endtask : t_frame

   task automatic t_parity();
      for (int o = 0; o < 2; o++) begin
         wr(SRE_OFS_MODE, 32'h1 | (32'(o) << SRE_MD_ODD));
         tx_u.send(8'hC3, 1'h1, 1'(o), 1'h1, 1'h1, 1'h0, 1'h0);
         rd_chk(SRE_OFS_STATUS, ST_PE);
         rd_chk(SRE_OFS_RDATA, 32'hC3);
         wr(SRE_OFS_CTRL, 32'h0);
         rd_chk(SRE_OFS_STATUS, ST_PE);
         // a write of 1 consumes the read record, so the following 0 must not clear
         wr(SRE_OFS_STATUS, 32'hFFFF_FFFF);
         wr(SRE_OFS_STATUS, 32'h0);
         rd_chk(SRE_OFS_STATUS, ST_PE);
         wr(SRE_OFS_CTRL, 32'h3);
         @(negedge clk_sys);
         `CHK(tx_allow, 1'h0)
         tx_u.send(8'h18, 1'h1, 1'(o), 1'h0, 1'h1, 1'h0, 1'h0);
         rd_chk(SRE_OFS_RDATA, 32'hC3);
         clr(ST_PE);
         @(negedge clk_sys);
         `CHK(tx_allow, 1'h1)
         wr(SRE_OFS_CTRL, 32'h1);
         tx_u.send(8'h18, 1'h1, 1'(o), 1'h0, 1'h1, 1'h0, 1'h0);
         rd_chk(SRE_OFS_STATUS, ST_RX);
         rd_chk(SRE_OFS_RDATA, 32'h18);
         clr(ST_RX);
      end
      $display("test parity done");
   endtask : t_parity

   task automatic t_standby();
      wr(SRE_OFS_MODE, 32'h1);
      tx_u.send(8'h66, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
      rd_chk(SRE_OFS_STATUS, ST_FE);
      standby <= 1'h1;
      repeat (2) @(posedge clk_sys);
      standby <= 1'h0;
      rd_chk(SRE_OFS_STATUS, 32'h0);
      tx_u.send(8'h66, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
      rd_chk(SRE_OFS_STATUS, ST_PE);
      standby <= 1'h1;
      repeat (2) @(posedge clk_sys);
      standby <= 1'h0;
      rd_chk(SRE_OFS_STATUS, 32'h0);
      $display("test standby done");
   endtask : t_standby

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      rst_n   = 1'h0;
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = 8'h0;
      pwdata  = 32'h0;
      standby = 1'h0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'h1;
      t_reset();
      t_good();
      t_frame();
      t_parity();
      t_standby();
      print_verdict();
   end
endmodule : testbench
